// >>> common/bcpwm_map.vh
// Purpose: Register map and timing constants of the converter PWM control
// Assumes: AXI4-Lite, byte address is four times the register index
// Notes: Indices kept as printed
`ifndef BCPWM_MAP_VH
`define BCPWM_MAP_VH
`define BCPWM_IDX_PDOWN 8'h0E
`define BCPWM_IDX_PERIOD 8'h5C
`define BCPWM_IDX_SWDLY 8'h5D
`define BCPWM_IDX_PWIDTH 8'h5E
`define BCPWM_IDX_CTRL 8'h60
`define BCPWM_BIT_POWER_OFF 4
`define BCPWM_BIT_CAL 7
`define BCPWM_BIT_POL 5
`define BCPWM_BIT_TRACK 0
`define BCPWM_RST_PDOWN 8'h10
`define BCPWM_RST_PERIOD 8'hFF
`define BCPWM_RST_SWDLY 8'h00
`define BCPWM_RST_CTRL 8'h00
`define BCPWM_OFF_EXTRA 4
`define BCPWM_CAL_CYCLES 5'h10
`endif

// >>> hdl/bcpwm_ctrl.v
// Purpose: PWM controller for an external buck-boost battery converter
// Assumes: aclk is the 16.384 MHz switching tick domain; inputs synchronous
// Notes: Registers over AXI4-Lite, byte address = index * 4
// Behaviour
// - Converter stays powered down while power-off bit 4 is one.
// - Switching period comes from the converter period register.
// - Switch drive output asserted for the reported pulse width each period.
// - Switch held off at least min_off_time plus four cycles per period.
// - Overload on supply monitors ends the pulse for the rest of period.
// - Assist output opposite to drive in bipolar variant, same otherwise.
// - Polarity flag read-only at switching-delay bit 5.
// - Battery sense registered each cycle as the below flag.
// - Tracking follows loop target; non-tracking floors at low battery level.
`default_nettype none
`include "bcpwm_map.vh"
module bcpwm_ctrl #(
    parameter SAME_POLARITY = 0,
    parameter DW = 8
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    // AXI4-Lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Converter sensing
    input wire battery_sense_in,
    input wire supply_monitor_high,
    input wire supply_monitor_low,
    input wire [DW-1:0] loop_target_level,
    input wire [DW-1:0] low_battery_level,
    // Switch drive
    output reg switch_drive_out,
    output reg switch_assist_out,
    output reg monitor_cal_active
);
    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    reg [7:0] pdown_reg;
    reg [7:0] period_reg;
    reg [4:0] min_off_time_reg;
    reg track_reg;
    reg [7:0] pwidth_reg;
    reg [7:0] cnt_reg;
    reg [7:0] on_len_reg;
    reg [7:0] on_cnt_reg;
    reg abort_reg;
    reg [4:0] cal_cnt_reg;
    reg [DW-1:0] target_reg;
    reg below_reg;
    reg [7:0] duty_reg;
    reg aw_got_reg;
    reg w_got_reg;
    reg [11:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    function [7:0] bcpwm_idx;
        input [11:0] a;
        begin
            bcpwm_idx = a[9:2];
        end
    endfunction

    function bcpwm_hit;
        input [7:0] idx;
        begin
            bcpwm_hit = (idx == `BCPWM_IDX_PDOWN) || (idx == `BCPWM_IDX_PERIOD) ||
                (idx == `BCPWM_IDX_SWDLY) || (idx == `BCPWM_IDX_PWIDTH) || (idx == `BCPWM_IDX_CTRL);
        end
    endfunction

    wire power_off = pdown_reg[`BCPWM_BIT_POWER_OFF];
    wire overload = supply_monitor_high | supply_monitor_low;
    wire polarity_flag = (SAME_POLARITY != 0);
    wire [7:0] off_min = {3'h0, min_off_time_reg} + 8'h04;
    wire period_end = (cnt_reg == 8'h00);

    // ---------------------------------------------------------------
    // Bus write path
    // ---------------------------------------------------------------
    assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire [7:0] widx = bcpwm_idx(aw_addr_reg);
    wire cal_write = do_write && widx == `BCPWM_IDX_SWDLY && w_strb_reg[0] && w_data_reg[`BCPWM_BIT_CAL];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            pdown_reg <= `BCPWM_RST_PDOWN;
            period_reg <= `BCPWM_RST_PERIOD;
            min_off_time_reg <= 5'h00;
            track_reg <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bcpwm_hit(widx) ? 2'h0 : 2'h2;
                if (w_strb_reg[0]) begin
                    if (widx == `BCPWM_IDX_PDOWN)
                        pdown_reg <= w_data_reg[7:0];
                    if (widx == `BCPWM_IDX_PERIOD)
                        period_reg <= w_data_reg[7:0];
                    if (widx == `BCPWM_IDX_SWDLY)
                        min_off_time_reg <= w_data_reg[4:0];
                    if (widx == `BCPWM_IDX_CTRL)
                        track_reg <= w_data_reg[`BCPWM_BIT_TRACK];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Bus read path
    // ---------------------------------------------------------------
    wire [7:0] ridx = bcpwm_idx(s_axi_araddr);
    reg [7:0] rval;
    always @* begin
        case (ridx)
            `BCPWM_IDX_PDOWN: rval = pdown_reg;
            `BCPWM_IDX_PERIOD: rval = period_reg;
            `BCPWM_IDX_SWDLY: rval = {monitor_cal_active, 1'b0, polarity_flag, min_off_time_reg};
            `BCPWM_IDX_PWIDTH: rval = pwidth_reg;
            `BCPWM_IDX_CTRL: rval = {6'h00, below_reg, track_reg};
            default: rval = 8'h00;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rval};
                s_axi_rresp <= bcpwm_hit(ridx) ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Regulation and calibration
    // ---------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            target_reg <= {DW{1'b0}};
            below_reg <= 1'b0;
            duty_reg <= 8'h00;
            cal_cnt_reg <= 5'h00;
            monitor_cal_active <= 1'b0;
        end else if (clk_en) begin
            // tracking or floor at low level
            if (track_reg || loop_target_level > low_battery_level)
                target_reg <= loop_target_level;
            else
                target_reg <= low_battery_level;
            below_reg <= battery_sense_in;
            if (cal_write && !power_off) begin
                monitor_cal_active <= 1'b1;
                cal_cnt_reg <= `BCPWM_CAL_CYCLES;
            end else if (cal_cnt_reg != 5'h00) begin
                cal_cnt_reg <= cal_cnt_reg - 5'h01;
            end else begin
                monitor_cal_active <= 1'b0;
            end
            if (power_off)
                duty_reg <= 8'h00;
            else if (period_end) begin
                if (below_reg && duty_reg != 8'hFF)
                    duty_reg <= duty_reg + 8'h01;
                else if (!below_reg && duty_reg != 8'h00)
                    duty_reg <= duty_reg - 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // PWM engine
    // ---------------------------------------------------------------
    wire [7:0] on_max = (period_reg > off_min) ? period_reg - off_min : 8'h00;
    wire [7:0] on_pick = (duty_reg > on_max) ? on_max : duty_reg;
    wire on_now = !power_off && !abort_reg && !overload && on_cnt_reg != 8'h00 && !monitor_cal_active;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
            on_len_reg <= 8'h00;
            on_cnt_reg <= 8'h00;
            abort_reg <= 1'b0;
            pwidth_reg <= 8'h00;
            switch_drive_out <= 1'b0;
            switch_assist_out <= 1'b0;
        end else if (clk_en) begin
            if (power_off) begin
                cnt_reg <= 8'h00;
                on_cnt_reg <= 8'h00;
                on_len_reg <= 8'h00;
                abort_reg <= 1'b0;
            end else if (period_end) begin
                cnt_reg <= period_reg;
                on_cnt_reg <= on_pick;
                on_len_reg <= 8'h00;
                pwidth_reg <= on_len_reg;
                abort_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 8'h01;
                if (overload)
                    abort_reg <= 1'b1;
                if (on_now) begin
                    on_cnt_reg <= on_cnt_reg - 8'h01;
                    on_len_reg <= on_len_reg + 8'h01;
                end
            end
            // on time capped to leave off time
            switch_drive_out <= on_now & !period_end;
            // assist follows drive in same variant, inverted otherwise
            switch_assist_out <= polarity_flag ? (on_now & !period_end) : !(on_now & !period_end);
        end
    end
endmodule
`default_nettype wire

// >>> bench/bcpwm_chk.sv
// Purpose: Port checker for the converter PWM control
// Assumes: One clock, sync active-low reset
// Notes: Bound to every bcpwm_ctrl instance
`default_nettype none
module bcpwm_chk #(parameter SAME_POLARITY = 0) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter side
    input wire logic supply_monitor_high,
    input wire logic supply_monitor_low,
    input wire logic switch_drive_out,
    input wire logic switch_assist_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ovl; (supply_monitor_high || supply_monitor_low) && clk_en |=> !switch_drive_out; endproperty
    a_ovl: assert property (p_ovl) else $error("drive on after overload");
    property p_toff; $fell(switch_drive_out) |-> !switch_drive_out [*4]; endproperty
    a_toff: assert property (p_toff) else $error("off time too short");
    property p_pol; $past(aresetn) |-> switch_assist_out == (SAME_POLARITY ? switch_drive_out : !switch_drive_out);
    endproperty
    a_pol: assert property (p_pol) else $error("assist polarity wrong");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_awref; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_awref: assert property (p_awref) else $error("aw taken during response");
    property p_arref; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arref: assert property (p_arref) else $error("ar taken during response");
endmodule
bind bcpwm_ctrl bcpwm_chk #(.SAME_POLARITY(SAME_POLARITY)) bcpwm_chk_i (.*);
`default_nettype wire

// >>> bench/bcpwm_conv.sv
// Purpose: Converter stage model
// Assumes: Bench sets demand and faults
// Notes: Behavioural
`default_nettype none
module bcpwm_conv #(parameter SAME_POLARITY = 0) (
    // Switch drive
    input wire logic switch_drive_out,
    input wire logic switch_assist_out,
    // Bench control
    input wire logic demand,
    input wire logic [1:0] fault,
    // Sense outputs
    output logic battery_sense_in,
    output logic supply_monitor_high,
    output logic supply_monitor_low
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic sw_on = SAME_POLARITY ? switch_assist_out : switch_drive_out;
    assign battery_sense_in = demand;
    assign supply_monitor_high = fault[1];
    assign supply_monitor_low = fault[0] & sw_on;
endmodule
`default_nettype wire

// >>> bench/bcpwm_tb.sv
// Purpose: Register and PWM tests
// Assumes: Bipolar variant, 4 ns clock
// Notes: Bus tasks follow AXI4-Lite
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, clk_en = 1, demand = 1, pd = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, fault = 0, rd_r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic battery_sense_in, supply_monitor_high, supply_monitor_low;
    logic switch_drive_out, switch_assist_out, monitor_cal_active;
    logic [7:0] loop_target_level = 8'h40, low_battery_level = 8'h20;
    int n_errors = 0, checks_done = 0, on_len = 0, per_len = 0, last_on = 0, last_per = 0, highs = 0, h = 0;
    bcpwm_ctrl #(.SAME_POLARITY(0), .DW(8)) bcpwm_ctrl_i (.*);
    bcpwm_conv #(.SAME_POLARITY(0)) bcpwm_conv_i (.*);
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        pd <= switch_drive_out;
        per_len <= (switch_drive_out && !pd) ? 1 : per_len + 1;
        on_len <= switch_drive_out ? on_len + 1 : 0;
        if (switch_drive_out && !pd) last_per <= per_len;
        if (!switch_drive_out && pd) last_on <= on_len;
        if (switch_drive_out) highs <= highs + 1;
    end
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit ad;
        bit dd;
        ad = 0;
        dd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) ad = 1;
            if (s_axi_wvalid && s_axi_wready) dd = 1;
            if (ad) s_axi_awvalid <= 0;
            if (dd) s_axi_wvalid <= 0;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk("bresp", 0, s_axi_bresp);
    endtask
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
    endtask
    task automatic rck(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(nm, e, rd_d & m);
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rck("pdown", 12'h038, 32'hFF, 32'h10);
        rck("period", 12'h170, 32'hFF, 32'hFF);
        rck("pol", 12'h174, 32'h20, 32'h00);
        rd(12'h100);
        chk("unmapped", 32'h2, {30'h0, rd_r});
        repeat (60) @(posedge aclk);
        chk("off_drive", 0, highs);
        wr(12'h170, 32'h13);
        wr(12'h174, 32'h23);
        rck("pol_ro", 12'h174, 32'h3F, 32'h03);
        wr(12'h038, 32'h00);
        repeat (800) @(posedge aclk);
        chk("per_len", 20, last_per);
        chk("on_max", 12, last_on);
        rck("pwidth", 12'h178, 32'hFF, 32'h0C);
        for (int i = 1; i < 3; i++) begin
            @(posedge switch_drive_out);
            @(posedge aclk);
            fault <= i[1:0];
            @(posedge aclk);
            fault <= 0;
            repeat (25) @(posedge aclk);
            chk("ovl_on", 1, last_on <= 3);
        end
        for (int i = 0; i < 2; i++) begin
            demand <= i[0];
            repeat (3) @(posedge aclk);
            rck("below", 12'h180, 32'h2, {30'h0, i[0], 1'b0});
        end
        wr(12'h180, 32'h01);
        rck("track", 12'h180, 32'h1, 32'h1);
        wr(12'h174, 32'h83);
        chk("cal_on", 1, monitor_cal_active);
        rck("cal_st", 12'h174, 32'h80, 32'h80);
        repeat (25) @(posedge aclk);
        chk("cal_off", 0, monitor_cal_active);
        wr(12'h038, 32'h10);
        repeat (30) @(posedge aclk);
        h = highs;
        repeat (60) @(posedge aclk);
        chk("off_again", h, highs);
        summarize();
    end
    initial begin
        #40000;
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
